/* pin_req_if.sv */
// Carrier between the register block and the pin request detector
`timescale 1ns/100ps
interface pin_req_if;
  logic [wakeup_irq_pkg::PIN_N-1:0] enables;
  logic mode;
  logic [wakeup_irq_pkg::PIN_N-1:0] request;
  modport ctrl (output enables, output mode, input request);
  modport det (input enables, input mode, output request);
endinterface

/* pin_request_detect.sv */
// Keyboard pin synchroniser and falling-edge / low-level request detector
`timescale 1ns/100ps
module pin_request_detect #(
  parameter int PIN_N = wakeup_irq_pkg::PIN_N
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PIN_N-1:0] pin_in,
  pin_req_if.det req
);
  logic [PIN_N-1:0] sync_a;
  logic [PIN_N-1:0] sync_b;
  logic [PIN_N-1:0] prev;
  logic [PIN_N-1:0] request;
  logic [PIN_N-1:0] next_request;

  // Falling edge requests on an enabled pin; low level too in level mode
  always_comb begin
    next_request = req.enables & ((prev & ~sync_b) | ({PIN_N{req.mode}} & ~sync_b));
  end

  // Two-stage synchroniser, history and request register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= {PIN_N{1'h1}};
      sync_b <= {PIN_N{1'h1}};
      prev <= {PIN_N{1'h1}};
      request <= {PIN_N{1'h0}};
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      prev <= sync_b;
      request <= next_request;
    end
  end

  assign req.request = request;

  AST_PIN_DISABLED_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(req.enables) == '0 |-> request == '0)
    else $error("Disabled pins raised a request");
endmodule

/* wakeup_irq_pkg.sv */
// Shared constants and types for the wakeup/keyboard interrupt latch
package wakeup_irq_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int PIN_N = 6;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 12'h004;
  // Status-and-control field positions
  localparam int BIT_PEND = 3;
  localparam int BIT_ACK = 2;
  localparam int BIT_MASK = 1;
  localparam int BIT_MODE = 0;
  localparam int STATUS_UNUSED_LO = 4;
  localparam int STATUS_UNUSED_HI = 7;
  // Enable register field positions
  localparam int BIT_WAKE_EN = 6;
  // Reset values
  localparam logic RST_BIT = 1'h0;
  localparam logic [PIN_N-1:0] RST_PIN_EN = 6'h00;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register selection
  typedef enum logic [1:0] {
    REG_STATUS = 2'h0,
    REG_ENABLE = 2'h1,
    REG_NONE = 2'h2
  } reg_sel_t;
  // Word-aligned address decode
  function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = REG_NONE;
    if (addr == OFS_STATUS_CONTROL) begin
      sel = REG_STATUS;
    end else if (addr == OFS_ENABLE) begin
      sel = REG_ENABLE;
    end
    return sel;
  endfunction
endpackage

/* wakeup_keyboard_irq_latch.sv */
`timescale 1ns/100ps
module wakeup_keyboard_irq_latch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [wakeup_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [wakeup_irq_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wakeup_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [wakeup_irq_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [wakeup_irq_pkg::PIN_N-1:0] pin_in,
  input wire logic wakeup_event,
  output logic irq
);
  localparam int PIN_N = wakeup_irq_pkg::PIN_N;
  localparam int DATA_W = wakeup_irq_pkg::DATA_W;
  localparam int ADDR_W = wakeup_irq_pkg::ADDR_W;

  // Bus state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic [DATA_W-1:0] wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic awready, next_awready;
  logic wready, next_wready;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic arready, next_arready;
  logic rvalid, next_rvalid;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  wakeup_irq_pkg::reg_sel_t rd_sel, next_rd_sel;
  // Block state
  logic pending, next_pending;
  logic mask, next_mask;
  logic mode, next_mode;
  logic wake_en, next_wake_en;
  logic [PIN_N-1:0] pin_en, next_pin_en;
  logic irq_q, next_irq;
  logic aw_take, w_take, ar_take, commit, set_req, ack_write;

  pin_req_if pin_req ();

  pin_request_detect #(.PIN_N(PIN_N)) u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_in),
    .req(pin_req)
  );

  // Settings toward the detector
  assign pin_req.enables = pin_en;
  assign pin_req.mode = mode;

  // Handshakes and write commit
  assign aw_take = s_axi_awvalid && awready;
  assign w_take = s_axi_wvalid && wready;
  assign ar_take = s_axi_arvalid && arready;
  assign commit = aw_held && w_held && !bvalid;
  assign ack_write = commit && (wakeup_irq_pkg::decode_reg(awaddr_q) == wakeup_irq_pkg::REG_STATUS)
    && wstrb_q[0] && wdata_q[wakeup_irq_pkg::BIT_ACK];
  // Wakeup sets only through its own enable, independent of mode and pin enables
  assign set_req = (|pin_req.request) | (wakeup_event & wake_en);

  // Next-state logic for bus and registers
  always_comb begin
    wakeup_irq_pkg::reg_sel_t wsel;
    logic [DATA_W-1:0] rd_word;
    wsel = wakeup_irq_pkg::REG_NONE;
    rd_word = wakeup_irq_pkg::RST_WORD;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_rd_sel = rd_sel;
    next_mask = mask;
    next_mode = mode;
    next_wake_en = wake_en;
    next_pin_en = pin_en;
    // Capture address and data in either order
    if (aw_take) begin
      next_aw_held = 1'h1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (w_take) begin
      next_w_held = 1'h1;
      next_wdata_q = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'h0;
    end
    // Apply a complete write; upper status bits and ack are not stored
    if (commit) begin
      wsel = wakeup_irq_pkg::decode_reg(awaddr_q);
      next_aw_held = 1'h0;
      next_w_held = 1'h0;
      next_bvalid = 1'h1;
      next_bresp = (wsel == wakeup_irq_pkg::REG_NONE) ? wakeup_irq_pkg::RESP_SLVERR : wakeup_irq_pkg::RESP_OKAY;
      if (wsel == wakeup_irq_pkg::REG_STATUS && wstrb_q[0]) begin
        next_mask = wdata_q[wakeup_irq_pkg::BIT_MASK];
        next_mode = wdata_q[wakeup_irq_pkg::BIT_MODE];
      end
      if (wsel == wakeup_irq_pkg::REG_ENABLE && wstrb_q[0]) begin
        next_wake_en = wdata_q[wakeup_irq_pkg::BIT_WAKE_EN];
        next_pin_en = wdata_q[PIN_N-1:0];
      end
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
    // Read path, one answer in flight
    if (ar_take) begin
      next_rd_sel = wakeup_irq_pkg::decode_reg(s_axi_araddr);
      case (next_rd_sel)
        wakeup_irq_pkg::REG_STATUS: begin
          rd_word[wakeup_irq_pkg::BIT_PEND] = pending;
          rd_word[wakeup_irq_pkg::BIT_MASK] = mask;
          rd_word[wakeup_irq_pkg::BIT_MODE] = mode;
        end
        wakeup_irq_pkg::REG_ENABLE: begin
          rd_word[wakeup_irq_pkg::BIT_WAKE_EN] = wake_en;
          rd_word[PIN_N-1:0] = pin_en;
        end
        default: begin
          rd_word = wakeup_irq_pkg::RST_WORD;
        end
      endcase
      next_rvalid = 1'h1;
      next_rdata = rd_word;
      next_rresp = (next_rd_sel == wakeup_irq_pkg::REG_NONE) ? wakeup_irq_pkg::RESP_SLVERR
        : wakeup_irq_pkg::RESP_OKAY;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'h0;
    end
    next_arready = !next_rvalid;
    // New request wins over a same-cycle acknowledge
    next_pending = (pending & ~ack_write) | set_req;
    next_irq = next_pending & ~next_mask;
  end

  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
      awaddr_q <= wakeup_irq_pkg::OFS_STATUS_CONTROL;
      wdata_q <= wakeup_irq_pkg::RST_WORD;
      wstrb_q <= 4'h0;
      awready <= 1'h1;
      wready <= 1'h1;
      bvalid <= 1'h0;
      bresp <= wakeup_irq_pkg::RESP_OKAY;
      arready <= 1'h1;
      rvalid <= 1'h0;
      rdata <= wakeup_irq_pkg::RST_WORD;
      rresp <= wakeup_irq_pkg::RESP_OKAY;
      rd_sel <= wakeup_irq_pkg::REG_NONE;
      pending <= wakeup_irq_pkg::RST_BIT;
      mask <= wakeup_irq_pkg::RST_BIT;
      mode <= wakeup_irq_pkg::RST_BIT;
      wake_en <= wakeup_irq_pkg::RST_BIT;
      pin_en <= wakeup_irq_pkg::RST_PIN_EN;
      irq_q <= wakeup_irq_pkg::RST_BIT;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      rd_sel <= next_rd_sel;
      pending <= next_pending;
      mask <= next_mask;
      mode <= next_mode;
      wake_en <= next_wake_en;
      pin_en <= next_pin_en;
      irq_q <= next_irq;
    end
  end

  // Port drive
  assign s_axi_awready = awready;
  assign s_axi_wready = wready;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = arready;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign irq = irq_q;

  // Checks
  sequence wake_latch_s;
    wakeup_event && wake_en;
  endsequence
  sequence ack_only_s;
    ack_write && !set_req;
  endsequence
  sequence wr_taken_s;
    aw_take && w_take;
  endsequence

  // Interrupt, status and latch behaviour
  AST_IRQ_TRACKS_PENDING: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == (pending && !mask))
    else $error("Interrupt output disagrees with pending and mask");
  AST_STATUS_UPPER_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && rd_sel == wakeup_irq_pkg::REG_STATUS |->
    rdata[wakeup_irq_pkg::STATUS_UNUSED_HI:wakeup_irq_pkg::STATUS_UNUSED_LO] == '0)
    else $error("Unused status bits read nonzero");
  AST_ACK_READS_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && rd_sel == wakeup_irq_pkg::REG_STATUS |-> !rdata[wakeup_irq_pkg::BIT_ACK])
    else $error("Acknowledge bit read as one");
  AST_WAKE_SETS_PENDING: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_latch_s |=> pending ##1 (pending || $past(ack_write)))
    else $error("Enabled wakeup event did not latch");
  AST_WAKE_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
    !pending && wakeup_event && !wake_en && pin_req.request == '0 |=> !pending)
    else $error("Disabled wakeup event latched a request");
  AST_ACK_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_only_s |=> !pending && !irq)
    else $error("Acknowledge did not clear pending");
  AST_PIN_SETS_PENDING: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_req.request != '0 |=> pending)
    else $error("Pin request did not latch");
  AST_RESET_CLEARS: assert property (@(posedge aclk) disable iff (1'h0)
    !aresetn |=> !pending && !mask && !wake_en && !irq)
    else $error("Reset left control bits set");
  AST_MASK_BLOCKS: assert property (@(posedge aclk) disable iff (!aresetn)
    mask [*2] |-> !irq)
    else $error("Masked request raised the interrupt");
  AST_PEND_ONLY_BY_REQUEST: assert property (@(posedge aclk) disable iff (!aresetn)
    !pending && !set_req |=> !pending)
    else $error("Pending set with no request");
  AST_PEND_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
    pending && !ack_write |=> pending)
    else $error("Pending cleared without acknowledge");
  AST_WAKE_IGNORES_PIN_CFG: assert property (@(posedge aclk) disable iff (!aresetn)
    wakeup_event && wake_en && (mode || pin_en != '0) |=> pending)
    else $error("Pin settings blocked a wakeup request");
  AST_STATUS_READ_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && wakeup_irq_pkg::decode_reg(s_axi_araddr) == wakeup_irq_pkg::REG_STATUS |=>
    rdata[wakeup_irq_pkg::BIT_PEND] == $past(pending))
    else $error("Status read did not show the pending flag");
  AST_ENABLE_UPPER_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && rd_sel == wakeup_irq_pkg::REG_ENABLE |->
    rdata[DATA_W-1:wakeup_irq_pkg::BIT_WAKE_EN+1] == '0)
    else $error("Unused enable bits read nonzero");

  // Register bus answers and holds
  AST_WRITE_ANSWERS: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_taken_s |-> ##2 s_axi_bvalid)
    else $error("Write response did not follow the accepted write");
  AST_READ_ANSWERS: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take |=> s_axi_rvalid)
    else $error("Read data did not follow the accepted address");
  AST_BVALID_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before it was taken");
  AST_RVALID_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read data dropped before it was taken");
  AST_AW_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_held |-> !s_axi_awready)
    else $error("Second write address accepted while one is held");
  AST_W_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
    w_held |-> !s_axi_wready)
    else $error("Second write data accepted while one is held");
  AST_AR_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address accepted while read data is pending");
  AST_UNMAPPED_WRITE_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && wakeup_irq_pkg::decode_reg(awaddr_q) == wakeup_irq_pkg::REG_NONE |=>
    s_axi_bresp == wakeup_irq_pkg::RESP_SLVERR)
    else $error("Unmapped write not answered with an error");
  AST_UNMAPPED_READ_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && wakeup_irq_pkg::decode_reg(s_axi_araddr) == wakeup_irq_pkg::REG_NONE |=>
    s_axi_rresp == wakeup_irq_pkg::RESP_SLVERR && s_axi_rdata == '0)
    else $error("Unmapped read not answered with an error");
endmodule

/* wakeup_keyboard_irq_latch_tb.sv */
// Self-checking bench for the wakeup/keyboard interrupt latch
`timescale 1ns/100ps
module wakeup_keyboard_irq_latch_tb;
  localparam logic [11:0] a_st = wakeup_irq_pkg::OFS_STATUS_CONTROL;
  localparam logic [11:0] a_en = wakeup_irq_pkg::OFS_ENABLE;
  localparam logic [11:0] a_bad = 12'h008;
  localparam logic [31:0] pend = 32'h1 << wakeup_irq_pkg::BIT_PEND;
  localparam logic [31:0] ack = 32'h1 << wakeup_irq_pkg::BIT_ACK;
  localparam logic [31:0] msk = 32'h1 << wakeup_irq_pkg::BIT_MASK;
  localparam logic [31:0] mode = 32'h1 << wakeup_irq_pkg::BIT_MODE;
  localparam logic [31:0] wen = 32'h1 << wakeup_irq_pkg::BIT_WAKE_EN;
  localparam logic [1:0] ok = wakeup_irq_pkg::RESP_OKAY;
  localparam logic [1:0] err = wakeup_irq_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [5:0] pin_in = 6'h3f;
  logic wakeup_event = 1'b0;
  logic irq;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  wakeup_keyboard_irq_latch dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
    .wakeup_event(wakeup_event), .irq(irq));

  // Clock at 4 ns
  initial begin
    forever #2 aclk = ~aclk;
  end

  // Hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Write one word, address and data offered together
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // Read one word and compare data and response
  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic pulse();
    @(posedge aclk);
    wakeup_event <= 1'b1;
    @(posedge aclk);
    wakeup_event <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_reset();
    axi_read(a_st, 32'h0, ok);
    axi_read(a_en, 32'h0, ok);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_wake();
    pulse();
    axi_read(a_st, 32'h0, ok);
    axi_write(a_en, wen, ok);
    axi_read(a_en, wen, ok);
    pulse();
    axi_read(a_st, pend, ok);
    chk("irq", 32'h1, {31'h0, irq});
  endtask

  // Mask with upper bits written high
  task automatic t_mask();
    axi_write(a_st, 32'hf2, ok);
    axi_read(a_st, pend | msk, ok);
    chk("irq", 32'h0, {31'h0, irq});
    axi_write(a_st, 32'h0, ok);
    chk("irq", 32'h1, {31'h0, irq});
  endtask

  task automatic t_ack();
    axi_read(a_st, pend, ok);
    axi_write(a_st, ack, ok);
    axi_read(a_st, 32'h0, ok);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  // Pin enables and mode select leave wakeup latching alone
  task automatic t_ignored();
    axi_write(a_en, 32'h3f, ok);
    axi_write(a_st, mode, ok);
    pulse();
    axi_read(a_st, mode, ok);
    axi_write(a_en, wen | 32'h3f, ok);
    pulse();
    axi_read(a_st, pend | mode, ok);
    axi_write(a_st, ack, ok);
    axi_read(a_st, 32'h0, ok);
  endtask

  // Each pin alone, after a disabled pin stays quiet
  task automatic t_pins();
    axi_write(a_en, 32'h0, ok);
    @(posedge aclk) pin_in <= 6'h00;
    repeat (8) @(posedge aclk);
    pin_in <= 6'h3f;
    axi_read(a_st, 32'h0, ok);
    for (int i = 0; i < 6; i++) begin
      axi_write(a_en, 32'h1 << i, ok);
      @(posedge aclk) pin_in <= ~(6'h01 << i);
      repeat (8) @(posedge aclk);
      pin_in <= 6'h3f;
      repeat (8) @(posedge aclk);
      axi_read(a_st, pend, ok);
      axi_write(a_st, ack, ok);
      axi_read(a_st, 32'h0, ok);
    end
  endtask

  // Unmapped address and a write with lane 0 off both leave registers alone
  task automatic t_unmapped();
    axi_write(a_bad, 32'hff, err);
    axi_read(a_bad, 32'h0, err);
    wstrb <= 4'h0;
    axi_write(a_en, wen, ok);
    wstrb <= 4'hf;
    axi_read(a_en, 32'h20, ok);
  endtask

  // Level mode relatches a pin held low across an acknowledge
  task automatic t_level();
    axi_write(a_st, mode, ok);
    pin_in <= 6'h1f;
    repeat (8) @(posedge aclk);
    axi_write(a_st, ack | mode, ok);
    axi_read(a_st, pend | mode, ok);
    pin_in <= 6'h3f;
    repeat (8) @(posedge aclk);
    axi_write(a_st, ack | mode, ok);
    axi_read(a_st, mode, ok);
    axi_write(a_st, 32'h0, ok);
  endtask

  // Reset in mid-run clears bits that were set
  task automatic t_midreset();
    axi_write(a_en, wen | 32'h3f, ok);
    axi_write(a_st, msk, ok);
    pulse();
    axi_read(a_st, pend | msk, ok);
    chk("irq", 32'h0, {31'h0, irq});
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(a_st, 32'h0, ok);
    axi_read(a_en, 32'h0, ok);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_wake();
    t_mask();
    t_ack();
    t_ignored();
    t_pins();
    t_level();
    t_unmapped();
    t_midreset();
    end_of_test();
  end
endmodule
